//--- shared/sdpe_pkg.sv
// constants for the shared digital line, pulse generator and encoder block
package sdpe_pkg;
   // ----------------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------------
   localparam int NUM_LINES    = 26;
   localparam int NUM_GENS     = 8;
   localparam int NUM_ENCS     = 4;
   localparam int DUR_W        = 32;
   localparam int CNT_W        = 32;

   // ----------------------------------------------------------------------
   // line map on the main io connector
   // ----------------------------------------------------------------------
   localparam int ENC_LINE_BASE = 0;  // encoder k: wave a at 2k, wave b at 2k+1
   localparam int GEN_LINE_BASE = 8;  // generator g on line 8+g

   // ----------------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int DUR_UNIT_NS   = 10;
   // a longest-free unit rounds up, never below one cycle
   localparam int UNIT_CYCLES   = ((DUR_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
                                  ((DUR_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // ----------------------------------------------------------------------
   // reset values and encodings
   // ----------------------------------------------------------------------
   localparam logic DIR_OUT      = 1'h0;
   localparam logic DIR_IN       = 1'h1;
   localparam logic SEL_GENERAL  = 1'h0;
   localparam logic SEL_GEN      = 1'h1;
   localparam logic [1:0] STEP_NONE = 2'h0;
   localparam logic [1:0] STEP_UP   = 2'h1;
   localparam logic [1:0] STEP_DOWN = 2'h3;

   typedef enum logic [1:0] {
      SDPE_GEN_IDLE = 2'b00,
      SDPE_GEN_HIGH = 2'b01,
      SDPE_GEN_LOW  = 2'b10
   } sdpe_gen_state_e;
endpackage

//--- rtl/sdpe_io.sv
// shared digital lines with pulse generators and quadrature encoder counters
`timescale 1ns/1ps

// Contract
// (RULE_01) twenty-six digital lines, each independently input or output.
// (RULE_02) direction word bit 0 means output, 1 means input.
// (RULE_03) output word gives driven level of every output line.
// (RULE_04) software reads all twenty-six line levels as one word.
// (RULE_05) pin select chooses general line or generator output per shared pin.
// (RULE_06) selected generator alone drives its pin; direction and output ignored.
// (RULE_07) generator-driven pins stay readable through the input word.
// (RULE_08) encoder lines need no select; input lines read and feed counters.
// (RULE_09) encoder lines set as outputs feed software level into counters.
// (RULE_10) eight generators, each waveform only while its enable is set.
// (RULE_11) high phase lasts the programmed number of duration units.
// (RULE_12) low phase lasts its own separate programmed number of units.
// (RULE_13) four quadrature counters with a and b waves, readable by software.
// (RULE_14) each counter cleared while its own reset flag is asserted.
// (RULE_15) high and low duration settings are each 32 bits wide.
// (RULE_16) counters decode quadrature, up or down per edge, wrap in 32 bits.
// (RULE_17) enabled generator alternates; disabled holds low, restarts high.
// (RULE_18) line inputs pass two flip-flops before any decoding.
module sdpe_io #(
   parameter int NUM_LINES = sdpe_pkg::NUM_LINES,
   parameter int NUM_GENS  = sdpe_pkg::NUM_GENS,
   parameter int NUM_ENCS  = sdpe_pkg::NUM_ENCS,
   parameter int DUR_W     = sdpe_pkg::DUR_W,
   parameter int CNT_W     = sdpe_pkg::CNT_W
) (
   input  wire logic                      clk_sys_i,
   input  wire logic                      reset_i,
   input  wire logic [NUM_LINES-1:0]      line_in_i,
   output logic      [NUM_LINES-1:0]      line_out_o,
   output logic      [NUM_LINES-1:0]      line_oe_o,
   input  wire logic [NUM_LINES-1:0]      dir_i,
   input  wire logic [NUM_LINES-1:0]      out_word_i,
   output logic      [NUM_LINES-1:0]      in_word_o,
   input  wire logic [NUM_GENS-1:0]       pin_select_i,
   input  wire logic [NUM_GENS-1:0]       gen_enable_i,
   input  wire logic [NUM_GENS*DUR_W-1:0] gen_high_i,
   input  wire logic [NUM_GENS*DUR_W-1:0] gen_low_i,
   input  wire logic [NUM_ENCS-1:0]       enc_reset_i,
   output logic      [NUM_ENCS*CNT_W-1:0] enc_count_o
);

   // ----------------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------------
   // encoder pairs and generators must fit on the lines without overlapping
   if (sdpe_pkg::ENC_LINE_BASE + 2 * NUM_ENCS > sdpe_pkg::GEN_LINE_BASE ||
       sdpe_pkg::GEN_LINE_BASE + NUM_GENS > NUM_LINES || DUR_W < 1 || CNT_W < 2) begin : g_bad_cfg
      $error("sdpe_io: line map does not fit the chosen sizes");
   end

   // ----------------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------------
   // quadrature step from previous and present a/b; double jumps are ignored
   function automatic logic [1:0] quad_step(input logic [1:0] prev_ab, input logic [1:0] cur_ab);
      logic [3:0] key;
      key = {prev_ab, cur_ab};
      case (key)
         4'h1, 4'h7, 4'he, 4'h8: quad_step = sdpe_pkg::STEP_UP;
         4'h2, 4'hb, 4'hd, 4'h4: quad_step = sdpe_pkg::STEP_DOWN;
         default:                quad_step = sdpe_pkg::STEP_NONE;
      endcase
   endfunction

   // a duration of zero still lasts one unit, so the output never stalls
   function automatic logic [DUR_W-1:0] last_tick(input logic [DUR_W-1:0] dur);
      last_tick = (dur == '0) ? '0 : dur - 1'b1;
   endfunction

   // ----------------------------------------------------------------------
   // input synchroniser
   // ----------------------------------------------------------------------
   logic [NUM_LINES-1:0] sync1_r;
   logic [NUM_LINES-1:0] sync2_r;

   // two stages; only the second is read by anything else
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= line_in_i;  // see (RULE_18)
         sync2_r <= sync1_r;    // see (RULE_18)
      end
   end

   // ----------------------------------------------------------------------
   // unit tick divider
   // ----------------------------------------------------------------------
   logic [15:0] unit_cnt_r;
   logic        unit_tick;

   // one unit is a whole number of clocks; at the nominal clock it is one
   assign unit_tick = (unit_cnt_r == 16'(sdpe_pkg::UNIT_CYCLES - 1));

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         unit_cnt_r <= '0;
      end else if (unit_tick) begin
         unit_cnt_r <= '0;
      end else begin
         unit_cnt_r <= unit_cnt_r + 16'h0001;
      end
   end

   // ----------------------------------------------------------------------
   // pulse generators
   // ----------------------------------------------------------------------
   sdpe_pkg::sdpe_gen_state_e gen_state_r [NUM_GENS];
   logic [DUR_W-1:0]          gen_cnt_r   [NUM_GENS];
   logic [NUM_GENS-1:0]       gen_lvl;

   for (genvar g = 0; g < NUM_GENS; g++) begin : g_gen
      logic [DUR_W-1:0] high_dur;
      logic [DUR_W-1:0] low_dur;
      assign high_dur   = gen_high_i[g*DUR_W +: DUR_W];  // see (RULE_15)
      assign low_dur    = gen_low_i[g*DUR_W +: DUR_W];   // see (RULE_15)
      assign gen_lvl[g] = (gen_state_r[g] == sdpe_pkg::SDPE_GEN_HIGH);

      // idle holds low; enable always starts a fresh high phase
      always_ff @(posedge clk_sys_i) begin
         if (reset_i) begin
            gen_state_r[g] <= sdpe_pkg::SDPE_GEN_IDLE;
            gen_cnt_r[g]   <= '0;
         end else if (!gen_enable_i[g]) begin
            gen_state_r[g] <= sdpe_pkg::SDPE_GEN_IDLE;  // see (RULE_10) (RULE_17)
            gen_cnt_r[g]   <= '0;
         end else begin
            case (gen_state_r[g])
               sdpe_pkg::SDPE_GEN_IDLE: begin
                  gen_state_r[g] <= sdpe_pkg::SDPE_GEN_HIGH;  // see (RULE_17)
                  gen_cnt_r[g]   <= '0;
               end
               sdpe_pkg::SDPE_GEN_HIGH: begin
                  if (unit_tick) begin
                     if (gen_cnt_r[g] >= last_tick(high_dur)) begin  // see (RULE_11)
                        gen_state_r[g] <= sdpe_pkg::SDPE_GEN_LOW;
                        gen_cnt_r[g]   <= '0;
                     end else begin
                        gen_cnt_r[g] <= gen_cnt_r[g] + 1'b1;
                     end
                  end
               end
               sdpe_pkg::SDPE_GEN_LOW: begin
                  if (unit_tick) begin
                     if (gen_cnt_r[g] >= last_tick(low_dur)) begin  // see (RULE_12)
                        gen_state_r[g] <= sdpe_pkg::SDPE_GEN_HIGH;  // see (RULE_17)
                        gen_cnt_r[g]   <= '0;
                     end else begin
                        gen_cnt_r[g] <= gen_cnt_r[g] + 1'b1;
                     end
                  end
               end
               default: begin
                  gen_state_r[g] <= sdpe_pkg::SDPE_GEN_IDLE;
                  gen_cnt_r[g]   <= '0;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // pin drivers and input word
   // ----------------------------------------------------------------------
   logic [NUM_LINES-1:0] drv_lvl;
   logic [NUM_LINES-1:0] drv_oe;

   // generator ownership overrides direction and output word on shared pins
   always_comb begin
      drv_lvl = out_word_i;                                  // see (RULE_03)
      drv_oe  = ~dir_i;                                      // see (RULE_01) (RULE_02)
      for (int g = 0; g < NUM_GENS; g++) begin
         if (pin_select_i[g] == sdpe_pkg::SEL_GEN) begin     // see (RULE_05)
            drv_lvl[sdpe_pkg::GEN_LINE_BASE + g] = gen_lvl[g];  // see (RULE_06)
            drv_oe[sdpe_pkg::GEN_LINE_BASE + g]  = 1'b1;        // see (RULE_06)
         end
      end
   end

   // driven lines read back their own level, so waveforms stay visible
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         line_out_o <= '0;
         line_oe_o  <= '0;
         in_word_o  <= '0;
      end else begin
         line_out_o <= drv_lvl;
         line_oe_o  <= drv_oe;
         in_word_o  <= (line_oe_o & line_out_o) | (~line_oe_o & sync2_r);  // see (RULE_04) (RULE_07)
      end
   end

   // ----------------------------------------------------------------------
   // quadrature encoders
   // ----------------------------------------------------------------------
   logic [1:0]       enc_prev_r [NUM_ENCS];
   logic [CNT_W-1:0] enc_cnt_r  [NUM_ENCS];

   for (genvar k = 0; k < NUM_ENCS; k++) begin : g_enc
      localparam int LA = sdpe_pkg::ENC_LINE_BASE + 2 * k;
      localparam int LB = LA + 1;
      logic [1:0] cur_ab;
      logic [1:0] step;

      // input lines feed the pin, output lines feed the software level
      assign cur_ab = {dir_i[LA] ? sync2_r[LA] : out_word_i[LA],   // see (RULE_08) (RULE_09)
                       dir_i[LB] ? sync2_r[LB] : out_word_i[LB]};  // see (RULE_08) (RULE_09)
      assign step   = quad_step(enc_prev_r[k], cur_ab);
      assign enc_count_o[k*CNT_W +: CNT_W] = enc_cnt_r[k];  // see (RULE_13)

      // plain add and subtract wrap naturally in the counter width
      always_ff @(posedge clk_sys_i) begin
         if (reset_i) begin
            enc_prev_r[k] <= '0;
            enc_cnt_r[k]  <= '0;
         end else begin
            enc_prev_r[k] <= cur_ab;
            if (enc_reset_i[k]) begin
               enc_cnt_r[k] <= '0;  // see (RULE_14)
            end else if (step == sdpe_pkg::STEP_UP) begin
               enc_cnt_r[k] <= enc_cnt_r[k] + 1'b1;  // see (RULE_16)
            end else if (step == sdpe_pkg::STEP_DOWN) begin
               enc_cnt_r[k] <= enc_cnt_r[k] - 1'b1;  // see (RULE_16)
            end
         end
      end
   end

endmodule

//--- testbench/sdpe_io_asserts.sv
// port checker for the shared line, generator and encoder block
`timescale 1ns/1ps
module sdpe_io_asserts #(
   parameter int NUM_LINES = 26,
   parameter int NUM_GENS  = 8,
   parameter int NUM_ENCS  = 4,
   parameter int CNT_W     = 32
) (
   input wire logic                      clk_sys_i,
   input wire logic                      reset_i,
   input wire logic [NUM_LINES-1:0]      line_out_o,
   input wire logic [NUM_LINES-1:0]      line_oe_o,
   input wire logic [NUM_LINES-1:0]      dir_i,
   input wire logic [NUM_LINES-1:0]      out_word_i,
   input wire logic [NUM_LINES-1:0]      in_word_o,
   input wire logic [NUM_GENS-1:0]       pin_select_i,
   input wire logic [NUM_GENS-1:0]       gen_enable_i,
   input wire logic [NUM_ENCS-1:0]       enc_reset_i,
   input wire logic [NUM_ENCS*CNT_W-1:0] enc_count_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);
   // ------------------------------------------------------------------
   // sequences
   // ------------------------------------------------------------------
   sequence s_gen_start;
      $rose(gen_enable_i[0]) && pin_select_i[0] ##1 gen_enable_i[0] && pin_select_i[0];
   endsequence
   sequence s_gen_off;
      (pin_select_i[1] && !gen_enable_i[1]) [*2];
   endsequence
   // a step of wave b alone from 00 is one count up
   sequence s_ab_up;
      dir_i[1:0] == 2'h0 && out_word_i[1:0] == 2'h0 ##1
         dir_i[1:0] == 2'h0 && out_word_i[1:0] == 2'h2 && !enc_reset_i[0];
   endsequence
   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   // first edge after reset still shows reset drive, so skip it
   AST_OE_DIR: assert property (!$past(reset_i) |->
      line_oe_o[25:16] == ~$past(dir_i[25:16]) && line_oe_o[7:0] == ~$past(dir_i[7:0]))
      else $error("line enable differs from direction word");
   AST_GEN_OE: assert property (!$past(reset_i) |->
      line_oe_o[15:8] == ($past(pin_select_i) | ~$past(dir_i[15:8])))
      else $error("shared pin enable wrong");
   AST_OUT: assert property (!$past(reset_i) |->
      (line_out_o & line_oe_o & ~{10'h0, $past(pin_select_i), 8'h0}) ==
      ($past(out_word_i) & ~$past(dir_i) & ~{10'h0, $past(pin_select_i), 8'h0}))
      else $error("driven level differs from output word");
   AST_IN_DRV: assert property (!$past(reset_i) |->
      (in_word_o & $past(line_oe_o)) == ($past(line_out_o) & $past(line_oe_o)))
      else $error("input word misses driven level");
   AST_GEN_START: assert property (s_gen_start |=> line_out_o[8])
      else $error("generator did not start high");
   AST_GEN_OFF: assert property (s_gen_off |=> !line_out_o[9])
      else $error("disabled generator not low");
   AST_ENC_CLR: assert property (enc_reset_i[0] |=> enc_count_o[31:0] == 32'h0)
      else $error("counter not cleared");
   AST_ENC_UP: assert property (s_ab_up |=>
      enc_count_o[31:0] == $past(enc_count_o[31:0]) + 32'h1)
      else $error("loopback step not counted up");
endmodule

bind sdpe_io sdpe_io_asserts #(.NUM_LINES(NUM_LINES), .NUM_GENS(NUM_GENS), .NUM_ENCS(NUM_ENCS), .CNT_W(CNT_W))
   u_asserts (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .line_out_o(line_out_o), .line_oe_o(line_oe_o),
   .dir_i(dir_i), .out_word_i(out_word_i), .in_word_o(in_word_o), .pin_select_i(pin_select_i),
   .gen_enable_i(gen_enable_i), .enc_reset_i(enc_reset_i), .enc_count_o(enc_count_o));

//--- testbench/sdpe_far_side.sv
// far-side model: external line drivers and one quadrature encoder
`timescale 1ns/1ps
module sdpe_far_side (
   input  wire logic        clk_sys_i,
   input  wire logic [25:0] drv_lvl_i,
   input  wire logic [25:0] drv_en_i,
   input  wire logic [25:0] ext_i,
   input  wire logic        step_i,
   input  wire logic        down_i,
   output logic      [25:0] wire_o
);
   logic [1:0]  ph_r = 2'h0;
   logic [25:0] far;
   // one gray step per request, so the waves never change together
   always_ff @(posedge clk_sys_i) begin
      if (step_i) begin
         ph_r <= down_i ? ph_r - 2'h1 : ph_r + 2'h1;
      end
   end
   // encoder sits on lines 2 and 3, wave a below wave b
   assign far    = {ext_i[25:4], ph_r[1] ^ ph_r[0], ph_r[1], ext_i[1:0]};
   assign wire_o = (drv_en_i & drv_lvl_i) | (~drv_en_i & far);
endmodule

//--- testbench/test_sdpe_io.sv
// self-checking bench for the shared line, generator and encoder block
`timescale 1ns/1ps
module test_sdpe_io;
   typedef struct {int due; int k; logic [31:0] v;} sdpe_note_s;
   logic         clk_sys_i = 1'b0, reset_i = 1'b1, step = 1'b0, down = 1'b0;
   logic [25:0]  line_in_i, line_out_o, line_oe_o, in_word_o, d, w;
   logic [25:0]  dir_i = '1, out_word_i = '0, ext = '0;
   logic [7:0]   pin_select_i = '0, gen_enable_i = '0, b;
   logic [255:0] gen_high_i = '0, gen_low_i = '0;
   logic [3:0]   enc_reset_i = '1;
   logic [127:0] enc_count_o;
   logic [31:0]  o [9], cnt = '0;
   int           n_mismatch = 0, tests_run = 0, cyc = 0, ph = 0, hi [8], lo [8];
   sdpe_note_s   q [$];
   string        nm [9] = '{"in_word", "line_out", "line_oe", "enc0", "enc1", "gen_out", "gen_in", "enc2", "enc3"};

   sdpe_io u_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .line_in_i(line_in_i), .line_out_o(line_out_o),
      .line_oe_o(line_oe_o), .dir_i(dir_i), .out_word_i(out_word_i), .in_word_o(in_word_o),
      .pin_select_i(pin_select_i), .gen_enable_i(gen_enable_i), .gen_high_i(gen_high_i), .gen_low_i(gen_low_i),
      .enc_reset_i(enc_reset_i), .enc_count_o(enc_count_o));
   sdpe_far_side u_far (.clk_sys_i(clk_sys_i), .drv_lvl_i(line_out_o), .drv_en_i(line_oe_o), .ext_i(ext),
      .step_i(step), .down_i(down), .wire_o(line_in_i));

   initial begin
      forever #50 clk_sys_i = ~clk_sys_i;
   end
   // observed items, indexed like the notes
   always_comb begin
      o = '{32'(in_word_o), 32'(line_out_o & line_oe_o), 32'(line_oe_o), enc_count_o[31:0],
            enc_count_o[63:32], 32'(line_out_o[15:8]), 32'(in_word_o[15:8]), enc_count_o[95:64],
            enc_count_o[127:96]};
   end
   always @(posedge clk_sys_i) cyc <= cyc + 1;
   // notes are pushed in due order, so the oldest is always next
   always @(negedge clk_sys_i) begin
      while (q.size() > 0 && q[0].due <= cyc) begin
         check(q[0].k, q[0].v, o[q[0].k]);
         void'(q.pop_front());
      end
   end

   task automatic check(input int k, input logic [31:0] e, input logic [31:0] s);
      tests_run++;
      if (s !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm[k], e, s);
      end
   endtask
   task automatic note(input int k, input int dl, input logic [31:0] v);
      q.push_back('{cyc + dl, k, v});
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask
   function automatic int mx(input int x);
      return x < 1 ? 1 : x;
   endfunction
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      #200000;
      n_mismatch++;
      finish_test();
   end

   initial begin
      ext = 26'($urandom(68863));
      tick(8);
      reset_i = 1'b0;
      // random directions and levels, counters held clear meanwhile
      for (int i = 0; i < 12; i++) begin
         d = 26'($urandom);
         w = 26'($urandom);
         dir_i = d;
         out_word_i = w;
         note(2, 1, {6'h0, ~d});
         note(1, 1, 32'(w & ~d));
         note(3, 1, 32'h0);
         note(0, 4, 32'((w & ~d) | ({ext[25:4], 2'h0, ext[1:0]} & d)));
         tick(4);
      end
      // generators on shared pins, zero duration acts as one cycle
      pin_select_i = 8'hff;
      for (int g = 0; g < 8; g++) begin
         hi[g] = $urandom_range(4);
         lo[g] = $urandom_range(4);
         gen_high_i[g*32 +: 32] = 32'(hi[g]);
         gen_low_i[g*32 +: 32] = 32'(lo[g]);
      end
      tick(2);
      gen_enable_i = 8'hff;
      out_word_i = ~out_word_i;
      note(2, 1, {6'h0, ~dir_i} | 32'hff00);
      for (int t = 2; t < 30; t++) begin
         for (int g = 0; g < 8; g++) begin
            b[g] = ((t - 2) % (mx(hi[g]) + mx(lo[g]))) < mx(hi[g]);
         end
         note(5, t, 32'(b));
         note(6, t + 1, 32'(b));
      end
      tick(30);
      gen_enable_i = 8'h00;
      note(5, 2, 32'h0);
      note(5, 3, 32'h0);
      tick(3);
      gen_enable_i = 8'hff;
      note(5, 2, 32'hff);
      tick(3);
      // loopback on encoders 0, 2 and 3, pins of encoder 1 from the far side
      out_word_i[7:0] = 8'h00;
      dir_i[7:0] = 8'h0c;
      tick(5);
      enc_reset_i = 4'h0;
      tick(1);
      for (int i = 0; i < 13; i++) begin
         ph += (i < 5) ? 1 : -1;
         cnt += (i < 5) ? 32'h1 : 32'hffffffff;
         out_word_i[1:0] = {ph[1] ^ ph[0], ph[1]};
         out_word_i[7:4] = {2{ph[1] ^ ph[0], ph[1]}};
         note(3, 1, cnt);
         note(7, 1, cnt);
         note(8, 1, cnt);
         tick(1);
      end
      // both waves at once must not count
      out_word_i[1:0] = ~out_word_i[1:0];
      out_word_i[7:4] = ~out_word_i[7:4];
      note(3, 1, cnt);
      note(7, 1, cnt);
      note(8, 1, cnt);
      tick(1);
      // each flag clears only its own counter
      enc_reset_i[2:0] = 3'h5;
      note(3, 1, 32'h0);
      note(7, 1, 32'h0);
      note(8, 1, cnt);
      for (int i = 0; i < 7; i++) begin
         down = i < 3;
         step = 1'b1;
         tick(1);
         step = 1'b0;
         tick(2);
      end
      tick(4);
      note(4, 1, 32'h1);
      tick(3);
      finish_test();
   end
endmodule
